// ### hdl/obr_bdev_role.sv
// Purpose: Role controller for a bus device that starts as peripheral
// Assumes: Line, power and plug inputs are synchronous to clk_i
// Notes:   Dual-role or peripheral-only selected by software
//
// What this block does
// - After the session request ends, go back to wait for far-end power.
// - Session voltage is always taken as far-end power, never own residue.
// - Session request signalling ends within 100 ms.
// - Entering request raises trying indication and starts response timer until peripheral.
// - Response timer hitting the limit, at most 30 s, flags no response.
// - Dual-role peripheral goes to await-host on host request, swap permit and suspend.
// - After own session request, swap on suspend even without host request.
// - Dual-role: A plug or session loss in active states returns to wait.
// - Entering peripheral switches the pull-up on and watches for bus reset.
// - Reset exists when the line is SE0 at or after the pull-up sample point.
// - A detected reset starts the high-speed detection handshake.
// - Entering await-host drops the pull-up and starts the connect wait timer.
// - Await-host returns to peripheral on timer expiry or far-end resume.
// - Far-end connect before expiry enters host within 1 ms.
// - Entering host drives bus reset, then starts frame generation.
// - Host stops frames and returns on request drop, disconnect or 30 s test.
// - Peripheral-only: wait to peripheral when session voltage is valid.
// - Peripheral-only request needs session request, session over and 2 ms SE0.
// - Peripheral-only request state returns to wait when the attempt completes.
// - Peripheral-only peripheral returns to wait when session voltage is lost.
// - Dual-role wait to peripheral with attach when session voltage valid.
// - Dual-role request needs host request, session over and 2 ms SE0.
// - Dual-role wait with A plug hands over to the far-end role.
`timescale 1ns/1ps
`default_nettype none
module obr_bdev_role
  import obr_pkg::*;
#(
  parameter int unsigned LINE_QUIET_CYC_P    = obr_pkg::LINE_QUIET_CYC,
  parameter int unsigned REQUEST_DONE_CYC_P  = obr_pkg::REQUEST_DONE_CYC,
  parameter int unsigned MS_CYC_P            = obr_pkg::MS_CYC,
  parameter int unsigned PULLUP_SAMPLE_CYC_P = obr_pkg::PULLUP_SAMPLE_CYC,
  parameter int unsigned HOST_CONN_WAIT_CYC_P = obr_pkg::HOST_CONN_WAIT_CYC,
  parameter int unsigned BUS_RESET_CYC_P     = obr_pkg::BUS_RESET_CYC,
  parameter int unsigned TEST_HOST_MS_P      = obr_pkg::TEST_HOST_MS
) (
  input  wire logic                        clk_i,
  input  wire logic                        reset_n_i,
  input  wire logic [obr_pkg::ADDR_W-1:0]  reg_addr_i,
  input  wire logic [obr_pkg::DATA_W-1:0]  reg_wdata_i,
  input  wire logic                        reg_we_i,
  input  wire logic                        reg_re_i,
  output logic      [obr_pkg::DATA_W-1:0]  reg_rdata_o,
  input  wire logic                        plug_type_pin_i,
  input  wire logic                        sess_ok_i,
  input  wire logic                        sess_over_i,
  input  wire logic                        line_se0_i,
  input  wire logic                        far_resume_seen_i,
  input  wire logic                        bus_suspend_i,
  input  wire logic                        far_connect_seen_i,
  input  wire logic                        test_dev_i,
  output logic                             own_attach_o,
  output logic                             own_frame_gen_o,
  output logic                             bus_reset_o,
  output logic                             request_sig_o,
  output logic                             trying_o,
  output logic                             no_response_o,
  output logic                             hs_detect_o,
  output logic                             take_a_role_o,
  output obr_pkg::obr_state_t              state_o
);

  // ==========================================================
  // Registers and timers
  obr_sfr_if sfr ();

  obr_core_s_t      s;
  obr_core_s_t      next_s;
  logic [TMR_W-1:0] st_limit;
  logic             st_tmr_done;
  logic             st_done;
  logic             quiet_ok;
  logic             ms_tick;
  logic             drop;
  logic             go_req;

  obr_regs u_regs (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .addr_i    (reg_addr_i),
    .wdata_i   (reg_wdata_i),
    .we_i      (reg_we_i),
    .re_i      (reg_re_i),
    .rdata_o   (reg_rdata_o),
    .sfr       (sfr.regs)
  );

  // SE0 must be seen for the full quiet minimum before a request
  obr_timer #(.W(TMR_W)) u_quiet (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .run_i     (line_se0_i),
    .limit_i   (TMR_W'(LINE_QUIET_CYC_P)),
    .done_o    (quiet_ok)
  );

  // One timer serves every state but wait; it restarts on each state change
  obr_timer #(.W(TMR_W)) u_state (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .run_i     (!s.fresh),
    .limit_i   (st_limit),
    .done_o    (st_tmr_done)
  );

  assign st_limit = (s.st == ST_REQ)    ? TMR_W'(REQUEST_DONE_CYC_P) :
                    (s.st == ST_PERIPH) ? TMR_W'(PULLUP_SAMPLE_CYC_P) :
                    (s.st == ST_AWAIT)  ? TMR_W'(HOST_CONN_WAIT_CYC_P) :
                    TMR_W'(BUS_RESET_CYC_P);
  // The timer still holds the previous state's count in the entry cycle
  assign st_done  = st_tmr_done && !s.fresh;
  assign ms_tick  = (s.ms_cnt >= TMR_W'(MS_CYC_P - 1));

  // Leaving an active state: peripheral-only ignores the plug
  assign drop   = !sess_ok_i || (sfr.dual_role && plug_type_pin_i);
  assign go_req = (sfr.dual_role ? sfr.host_req : sfr.sess_req) && sess_over_i && quiet_ok;

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_s        = s;
    next_s.fresh  = 1'b0;
    next_s.hs_det = 1'b0;
    next_s.ms_cnt = ms_tick ? '0 : s.ms_cnt + 1'b1;

    // Response timer keeps running after the request until peripheral
    if (s.resp_run) begin
      if (s.resp_ms >= sfr.resp_limit) begin
        next_s.no_resp  = 1'b1;
        next_s.resp_run = 1'b0;
      end else if (ms_tick) begin
        next_s.resp_ms = s.resp_ms + 1'b1;
      end
    end

    // Test device time only accrues while hosting it
    if (s.st != ST_HOST) begin
      next_s.test_ms = '0;
    end else if (test_dev_i && ms_tick && s.test_ms < MS_W'(TEST_HOST_MS_P)) begin
      next_s.test_ms = s.test_ms + 1'b1;
    end

    case (s.st)
      ST_WAIT: begin
        if (sfr.dual_role && plug_type_pin_i) begin
          next_s.a_role = 1'b1;
        end else if (sess_ok_i) begin
          // Voltage after our own request is still far-end power
          next_s.st     = ST_PERIPH;
          next_s.a_role = 1'b0;
        end else if (go_req) begin
          next_s.st     = ST_REQ;
          next_s.a_role = 1'b0;
        end else begin
          next_s.a_role = 1'b0;
        end
      end
      ST_REQ: begin
        if (st_done) begin
          next_s.st = ST_WAIT;
        end
      end
      ST_PERIPH: begin
        if (drop) begin
          next_s.st = ST_WAIT;
        end else if (sfr.dual_role && sfr.swap_permit && bus_suspend_i &&
                     (sfr.host_req || s.own_srp)) begin
          next_s.st = ST_AWAIT;
        end else if (s.attach && st_done && line_se0_i && !s.se0_seen) begin
          next_s.hs_det = 1'b1;
        end
      end
      ST_AWAIT: begin
        if (drop) begin
          next_s.st = ST_WAIT;
        end else if (st_done || far_resume_seen_i) begin
          next_s.st = ST_PERIPH;
        end else if (far_connect_seen_i) begin
          next_s.st = ST_HOST;
        end
      end
      ST_HOST: begin
        if (drop) begin
          next_s.st = ST_WAIT;
        end else if (!sfr.host_req || !far_connect_seen_i || s.test_ms >= MS_W'(TEST_HOST_MS_P)) begin
          next_s.st = ST_PERIPH;
        end else if (s.bus_rst && st_done) begin
          next_s.bus_rst   = 1'b0;
          next_s.frame_gen = 1'b1;
        end
      end
      default: begin
        next_s.st = ST_WAIT;
      end
    endcase

    // One reset report per SE0 stretch
    next_s.se0_seen = line_se0_i && (s.se0_seen || next_s.hs_det);

    // Entry actions, common to every transition
    if (next_s.st != s.st) begin
      next_s.fresh     = 1'b1;
      next_s.attach    = (next_s.st == ST_PERIPH);
      next_s.frame_gen = 1'b0;
      next_s.bus_rst   = (next_s.st == ST_HOST);
      next_s.req_sig   = (next_s.st == ST_REQ);
      if (next_s.st == ST_REQ) begin
        next_s.trying   = 1'b1;
        next_s.resp_run = 1'b1;
        next_s.resp_ms  = '0;
        next_s.no_resp  = 1'b0;
        next_s.own_srp  = 1'b1;
      end
      if (next_s.st == ST_PERIPH) begin
        next_s.trying   = 1'b0;
        next_s.resp_run = 1'b0;
        next_s.no_resp  = 1'b0;
      end
      // The session ends on any fall back to wait except after a request
      if (next_s.st == ST_WAIT && s.st != ST_REQ) begin
        next_s.own_srp = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= CORE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs and status
  assign own_attach_o    = s.attach;
  assign own_frame_gen_o = s.frame_gen;
  assign bus_reset_o     = s.bus_rst;
  assign request_sig_o   = s.req_sig;
  assign trying_o        = s.trying;
  assign no_response_o   = s.no_resp;
  assign hs_detect_o     = s.hs_det;
  assign take_a_role_o   = s.a_role;
  assign state_o         = s.st;
  assign sfr.status      = {20'h0, s.bus_rst, s.own_srp, s.a_role, s.no_resp,
                            s.trying, s.frame_gen, s.attach, s.st};

  // ==========================================================
  // Checks
  req_exit_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (s.st == ST_REQ && st_done) |=> (s.st == ST_WAIT && !request_sig_o))
    else $error("request state not left when signalling completed");

  sess_power_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (s.st == ST_WAIT && sess_ok_i && !(sfr.dual_role && plug_type_pin_i))
    |=> (s.st == ST_PERIPH && own_attach_o))
    else $error("valid session voltage did not lead to peripheral with attach");

  trying_ind_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (s.st != ST_REQ ##1 s.st == ST_REQ) |-> (trying_o && !no_response_o && s.resp_ms == 0))
    else $error("request entry did not raise trying and clear the response timer");

  no_resp_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (s.resp_run && s.resp_ms >= sfr.resp_limit && s.st != ST_PERIPH && !s.fresh &&
     !(s.st == ST_WAIT && (sess_ok_i || go_req)))
    |=> no_response_o)
    else $error("no-response flag missing at the response limit");

  swap_enter_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (s.st == ST_PERIPH && !drop && sfr.dual_role && sfr.host_req && sfr.swap_permit && bus_suspend_i)
    |=> (s.st == ST_AWAIT && !own_attach_o) ##1 (s.st != ST_AWAIT || !own_attach_o))
    else $error("await-host not entered with pull-up off");

  drop_wait_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (sfr.dual_role && (s.st == ST_PERIPH || s.st == ST_AWAIT || s.st == ST_HOST) && drop)
    |=> (s.st == ST_WAIT && !own_frame_gen_o && !own_attach_o))
    else $error("plug or session loss did not return to wait");

  resume_back_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (s.st == ST_AWAIT && !drop && far_resume_seen_i) |=> (s.st == ST_PERIPH && own_attach_o))
    else $error("far-end resume did not return to peripheral");

  connect_host_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (s.st == ST_AWAIT && !drop && !st_done && !far_resume_seen_i && far_connect_seen_i)
    |=> (s.st == ST_HOST && bus_reset_o && !own_frame_gen_o))
    else $error("far-end connect did not enter host with bus reset");

  frame_order_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(own_frame_gen_o) |-> (s.st == ST_HOST && $past(bus_reset_o) && !bus_reset_o))
    else $error("frames started without a preceding bus reset");

  host_leave_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (s.st == ST_HOST && !drop && (!sfr.host_req || !far_connect_seen_i))
    |=> (s.st == ST_PERIPH && !own_frame_gen_o))
    else $error("host not left when request or connect dropped");

  own_swap_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (s.st == ST_PERIPH && !drop && sfr.dual_role && sfr.swap_permit && bus_suspend_i && s.own_srp)
    |=> (s.st == ST_AWAIT))
    else $error("swap after own session request did not reach await-host");

  reset_detect_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    hs_detect_o |-> (s.st == ST_PERIPH && own_attach_o && $past(line_se0_i)))
    else $error("high-speed handshake started without SE0 in peripheral");

  only_periph_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (!sfr.dual_role && s.st == ST_WAIT && sess_ok_i) |=> (s.st == ST_PERIPH && own_attach_o))
    else $error("peripheral-only device did not attach on session voltage");

  only_drop_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (!sfr.dual_role && s.st == ST_PERIPH && !sess_ok_i) |=> (s.st == ST_WAIT && !own_attach_o))
    else $error("peripheral-only device did not fall back to wait on session loss");

  a_role_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (s.st == ST_WAIT && sfr.dual_role && plug_type_pin_i) |=> (s.st == ST_WAIT && take_a_role_o))
    else $error("A plug in wait did not hand over to the far-end role");

  reset_state_a: assert property (
    @(posedge clk_i)
    $rose(reset_n_i) |-> (s.st == ST_WAIT && !own_attach_o && !own_frame_gen_o && s.resp_ms == 0))
    else $error("reset did not leave the idle state");

endmodule // obr_bdev_role
`default_nettype wire

// ### hdl/obr_pkg.sv
// Purpose: Shared types, register map and timing constants for the B-device role controller
// Assumes: 250 MHz system clock
// Notes:   Times are kept in their own unit; cycle counts derive from them
package obr_pkg;

  // ==========================================================
  // Role states
  typedef enum logic [4:0] {
    ST_WAIT   = 5'h01,
    ST_REQ    = 5'h02,
    ST_PERIPH = 5'h04,
    ST_AWAIT  = 5'h08,
    ST_HOST   = 5'h10
  } obr_state_t;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_KHZ             = 250000;
  localparam int unsigned LINE_QUIET_MIN_MS   = 2;
  localparam int unsigned LINE_QUIET_CYC      = LINE_QUIET_MIN_MS * CLK_KHZ;
  localparam int unsigned REQUEST_DONE_MAX_MS = 100;
  localparam int unsigned REQUEST_DONE_CYC    = REQUEST_DONE_MAX_MS * CLK_KHZ;
  localparam int unsigned MS_CYC              = CLK_KHZ;
  localparam int unsigned PULLUP_SAMPLE_US    = 100;
  localparam int unsigned PULLUP_SAMPLE_CYC   = PULLUP_SAMPLE_US * CLK_KHZ / 1000;
  localparam int unsigned HOST_CONN_WAIT_MS   = 10;
  localparam int unsigned HOST_CONN_WAIT_CYC  = HOST_CONN_WAIT_MS * CLK_KHZ;
  localparam int unsigned BUS_RESET_MS        = 10;
  localparam int unsigned BUS_RESET_CYC       = BUS_RESET_MS * CLK_KHZ;
  localparam int unsigned SWAP_CONNECT_MAX_MS = 1;
  localparam int unsigned REQUEST_FAIL_MAX_S  = 30;
  localparam int unsigned REQUEST_FAIL_MAX_MS = REQUEST_FAIL_MAX_S * 1000;
  localparam int unsigned TEST_HOST_S         = 30;
  localparam int unsigned TEST_HOST_MS        = TEST_HOST_S * 1000;
  localparam int unsigned TMR_W               = 32;
  localparam int unsigned MS_W                = 15;

  // ==========================================================
  // Register map
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_LIMIT   = 8'h04;
  localparam logic [7:0]  REG_STATUS  = 8'h08;
  localparam int unsigned CTRL_W      = 4;
  localparam int unsigned CTRL_DUAL   = 0;
  localparam int unsigned CTRL_HREQ   = 1;
  localparam int unsigned CTRL_SREQ   = 2;
  localparam int unsigned CTRL_SWAP   = 3;
  localparam logic [3:0]  CTRL_RESET  = 4'h1;
  localparam logic [14:0] LIMIT_RESET = 15'(REQUEST_FAIL_MAX_MS);

  // ==========================================================
  // Core state
  typedef struct packed {
    obr_state_t         st;
    logic               fresh;
    logic               attach;
    logic               frame_gen;
    logic               bus_rst;
    logic               req_sig;
    logic               trying;
    logic               no_resp;
    logic               hs_det;
    logic               a_role;
    logic               own_srp;
    logic               resp_run;
    logic               se0_seen;
    logic [TMR_W-1:0]   ms_cnt;
    logic [MS_W-1:0]    resp_ms;
    logic [MS_W-1:0]    test_ms;
  } obr_core_s_t;

  localparam obr_core_s_t CORE_RESET = '{st: ST_WAIT, default: '0};

endpackage

// ### hdl/obr_regs.sv
// Purpose: Control, limit and status registers on a plain strobe port
// Assumes: Strobes one cycle, never together
// Notes:   Read data valid only in the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module obr_regs
  import obr_pkg::*;
(
  input  wire logic                        clk_i,
  input  wire logic                        reset_n_i,
  input  wire logic [obr_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [obr_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                        we_i,
  input  wire logic                        re_i,
  output logic      [obr_pkg::DATA_W-1:0]  rdata_o,
  obr_sfr_if.regs                          sfr
);
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [MS_W-1:0]   limit;
    logic [DATA_W-1:0] rdata;
  } obr_regs_s_t;

  obr_regs_s_t s;
  obr_regs_s_t next_s;

  always_comb begin
    next_s       = s;
    next_s.rdata = '0;
    if (we_i) begin
      if (addr_i == REG_CTRL) begin
        next_s.ctrl = wdata_i[CTRL_W-1:0];
      end else if (addr_i == REG_LIMIT) begin
        // Clamp so the no-response limit never exceeds the longest allowed
        next_s.limit = (wdata_i > DATA_W'(REQUEST_FAIL_MAX_MS)) ? LIMIT_RESET : wdata_i[MS_W-1:0];
      end
    end
    if (re_i) begin
      if (addr_i == REG_CTRL) begin
        next_s.rdata = {28'h0, s.ctrl};
      end else if (addr_i == REG_LIMIT) begin
        next_s.rdata = {17'h0, s.limit};
      end else if (addr_i == REG_STATUS) begin
        next_s.rdata = sfr.status;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '{ctrl: CTRL_RESET, limit: LIMIT_RESET, rdata: '0};
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o         = s.rdata;
  assign sfr.dual_role   = s.ctrl[CTRL_DUAL];
  assign sfr.host_req    = s.ctrl[CTRL_HREQ];
  assign sfr.sess_req    = s.ctrl[CTRL_SREQ];
  assign sfr.swap_permit = s.ctrl[CTRL_SWAP];
  assign sfr.resp_limit  = s.limit;
endmodule // obr_regs
`default_nettype wire

// ### hdl/obr_sfr_if.sv
// Purpose: Carries software control and core status between register file and role core
// Assumes: Single clock domain
// Notes:   Plain wires, no clocking
`timescale 1ns/1ps
`default_nettype none
interface obr_sfr_if;
  logic        dual_role;
  logic        host_req;
  logic        sess_req;
  logic        swap_permit;
  logic [14:0] resp_limit;
  logic [31:0] status;

  modport regs (output dual_role, host_req, sess_req, swap_permit, resp_limit, input status);
  modport core (input dual_role, host_req, sess_req, swap_permit, resp_limit, output status);
endinterface
`default_nettype wire

// ### hdl/obr_timer.sv
// Purpose: Saturating interval timer, cleared whenever run_i is low
// Assumes: limit_i stable while running
// Notes:   done_o high once limit_i cycles have been counted
`timescale 1ns/1ps
`default_nettype none
module obr_timer #(
  parameter int unsigned W = 32
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic         run_i,
  input  wire logic [W-1:0] limit_i,
  output logic              done_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } obr_tmr_s_t;

  obr_tmr_s_t s;
  obr_tmr_s_t next_s;

  always_comb begin
    next_s = s;
    if (!run_i) begin
      next_s.cnt = '0;
    end else if (s.cnt < limit_i) begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done_o = run_i && (s.cnt >= limit_i);
endmodule // obr_timer
`default_nettype wire

// ### verif/obr_adev_model.sv
// Purpose: Far-end host model that powers the bus
// Assumes: One clock
// Notes:   Answers a request only when told to
`timescale 1ns/1ps
`default_nettype none
module obr_adev_model (
  input  wire logic clk_i,
  input  wire logic answer_i,
  input  wire logic conn_en_i,
  input  wire logic req_i,
  input  wire logic attach_i,
  output logic      sess_ok_o,
  output logic      sess_over_o,
  output logic      conn_o
);
  // ====================
  // Power comes up only after the request has ended
  logic       pend = 1'b0;
  logic [1:0] dly  = 2'h0;
  always_ff @(posedge clk_i) begin
    if (!answer_i) pend <= 1'b0;
    else if (req_i) pend <= 1'b1;
    dly <= {dly[0], conn_en_i && !attach_i && sess_ok_o};
  end
  assign sess_ok_o   = pend && !req_i;
  assign sess_over_o = !sess_ok_o;
  assign conn_o      = dly[1];
endmodule // obr_adev_model
`default_nettype wire

// ### verif/obr_bdev_role_tb.sv
// Purpose: Self-checking bench for the role controller
// Assumes: Shortened timer parameters
// Notes:   Far end is obr_adev_model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin n_compared++; if ((g)!==(e)) begin n_errors++; $display("FAIL %s exp %h got %h",n,e,g); end end
module obr_bdev_role_tb;
  import obr_pkg::*;
  // ====================
  // Signals
  logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic plug = 1'b0, se0 = 1'b0, susp = 1'b0, answer = 1'b0, conn_en = 1'b0;
  logic resume = 1'b0, tdev = 1'b0;
  logic sok, sover, conn, att, frm, brst, req, tryg, nores, hs, arole;
  obr_state_t st;
  int n_errors = 0, n_compared = 0;
  always #2 clk = ~clk;
  obr_bdev_role #(.LINE_QUIET_CYC_P(20), .REQUEST_DONE_CYC_P(30), .MS_CYC_P(10),
    .PULLUP_SAMPLE_CYC_P(5), .HOST_CONN_WAIT_CYC_P(40), .BUS_RESET_CYC_P(8), .TEST_HOST_MS_P(3)) u_obr_bdev_role (
    .clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we),
    .reg_re_i(re), .reg_rdata_o(rdata), .plug_type_pin_i(plug), .sess_ok_i(sok),
    .sess_over_i(sover), .line_se0_i(se0), .far_resume_seen_i(resume), .bus_suspend_i(susp),
    .far_connect_seen_i(conn), .test_dev_i(tdev), .own_attach_o(att), .own_frame_gen_o(frm),
    .bus_reset_o(brst), .request_sig_o(req), .trying_o(tryg), .no_response_o(nores),
    .hs_detect_o(hs), .take_a_role_o(arole), .state_o(st));
  obr_adev_model u_obr_adev_model (.clk_i(clk), .answer_i(answer), .conn_en_i(conn_en),
    .req_i(req), .attach_i(att), .sess_ok_o(sok), .sess_over_o(sover), .conn_o(conn));
  // ====================
  // Helpers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; we <= 1'b1; end
    @(posedge clk) we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) begin addr <= a; re <= 1'b1; end
    @(posedge clk) re <= 1'b0;
    #1 `CHK("rdata", e, rdata)
  endtask
  task automatic wait_st(input obr_state_t s);
    repeat (300) if (st !== s) begin @(posedge clk); #1; end
    `CHK("state", s, st)
  endtask
  task automatic wait_hi(ref logic b, input string n);
    repeat (300) if (b !== 1'b1) begin @(posedge clk); #1; end
    `CHK(n, 1'b1, b)
  endtask
  task automatic test_done();
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ====================
  // Scenarios
  task automatic t_reset();
    `CHK("state", ST_WAIT, st)
    `CHK("attach", 1'b0, att)
    rd(REG_CTRL, 32'h1);
    rd(REG_LIMIT, 32'h7530);
    rd(8'h0c, 32'h0);
  endtask
  task automatic t_srp();
    int n = 0;
    answer <= 1'b1;
    se0 <= 1'b1;
    wr(REG_CTRL, 32'h3);
    wait_st(ST_REQ);
    `CHK("trying", 1'b1, tryg)
    `CHK("req sig", 1'b1, req)
    while (st === ST_REQ && n < 100) begin n++; @(posedge clk); #1; end
    // Limit of 30 plus the entry cycle and the timer restart cycle
    `CHK("req len", 32, n)
    wait_st(ST_PERIPH);
    `CHK("req sig", 1'b0, req)
    `CHK("attach", 1'b1, att)
    wait_hi(hs, "hs");
  endtask
  task automatic t_swap();
    se0 <= 1'b0;
    susp <= 1'b1;
    wr(REG_CTRL, 32'hb);
    wait_st(ST_AWAIT);
    `CHK("attach", 1'b0, att)
    wait_st(ST_PERIPH);
    wait_st(ST_AWAIT);
    resume <= 1'b1;
    wait_st(ST_PERIPH);
    resume <= 1'b0;
    conn_en <= 1'b1;
    wait_st(ST_HOST);
    `CHK("bus rst", 1'b1, brst)
    wait_hi(frm, "frames");
    `CHK("bus rst", 1'b0, brst)
    tdev <= 1'b1;
    wait_st(ST_PERIPH);
    `CHK("frames", 1'b0, frm)
    tdev <= 1'b0;
    susp <= 1'b0;
    @(posedge clk) susp <= 1'b1;
    wait_st(ST_HOST);
    wr(REG_CTRL, 32'h9);
    wait_st(ST_PERIPH);
    `CHK("frames", 1'b0, frm)
    susp <= 1'b0;
    conn_en <= 1'b0;
  endtask
  task automatic t_nores();
    answer <= 1'b0;
    wait_st(ST_WAIT);
    wr(REG_LIMIT, 32'h1);
    se0 <= 1'b1;
    wr(REG_CTRL, 32'h3);
    wait_hi(nores, "no resp");
    se0 <= 1'b0;
    plug <= 1'b1;
    wait_hi(arole, "a role");
  endtask
  task automatic t_ponly();
    plug <= 1'b0;
    answer <= 1'b1;
    se0 <= 1'b1;
    wr(REG_CTRL, 32'h4);
    wait_st(ST_REQ);
    wait_st(ST_WAIT);
    wait_st(ST_PERIPH);
    plug <= 1'b1;
    se0 <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("state", ST_PERIPH, st)
    answer <= 1'b0;
    wait_st(ST_WAIT);
    `CHK("a role", 1'b0, arole)
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_srp();
    t_swap();
    t_nores();
    t_ponly();
    test_done();
  end
  initial begin
    #40000;
    n_errors++;
    test_done();
  end
endmodule // obr_bdev_role_tb
`default_nettype wire
